/* nir_pkg.sv */
// Constants and types for the oscillator increment register block.
// Assumes a 32-bit AXI4-Lite master and a 12-bit byte address space.
package nir_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned INC_W  = 20;

   typedef struct packed {
      logic [3:0] upper;
      logic [7:0] high;
      logic [7:0] low;
   } nir_inc_t;

   localparam logic [7:0] LOW_RST   = 8'h01;
   localparam logic [7:0] HIGH_RST  = 8'h00;
   localparam logic [3:0] UPPER_RST = 4'h0;
   localparam nir_inc_t   INC_RST   = '{upper: UPPER_RST, high: HIGH_RST, low: LOW_RST};

   localparam logic [ADDR_W-1:0] OFF_LOW    = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_HIGH   = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_UPPER  = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_SHADOW = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_PHASE  = 12'h018;

   localparam int unsigned CTRL_RUN_BIT  = 0;
   localparam logic        CTRL_RUN_RST  = 1'b0;
   localparam int unsigned STAT_PEND_BIT = 0;
   localparam int unsigned STAT_OSC_BIT  = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* nir_phase_acc.sv */
// Phase accumulator fed by the buffered increment.
// Assumes step_i is a one-cycle pulse in the mclk_i domain.
`timescale 1ns/1ps
module nir_phase_acc
   import nir_pkg::*;
(
   input  wire logic             mclk_i,
   input  wire logic             rstn_i,
   input  wire logic             step_i,
   input  wire logic [INC_W-1:0] inc_i,
   output logic      [INC_W-1:0] phase_o,
   output logic                  carry_o
);

   logic [INC_W-1:0] phase_q;
   logic [INC_W-1:0] phase_d;
   logic             carry_q;
   logic             carry_d;
   logic [INC_W:0]   sum;

   // Wraps modulo 2^20; the carry is the oscillator overflow
   assign sum     = {1'b0, phase_q} + {1'b0, inc_i};
   assign phase_d = step_i ? sum[INC_W-1:0] : phase_q;
   assign carry_d = step_i & sum[INC_W];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_q <= '0;
         carry_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         carry_q <= carry_d;
      end
   end

   assign phase_o = phase_q;
   assign carry_o = carry_q;

endmodule

/* nir_top.sv */
// Oscillator increment registers with AXI4-Lite access and a shadow buffer.
// Assumes osc_clk_i is synchronous to mclk_i and slower than mclk_i / 2.
`timescale 1ns/1ps
module nir_top
   import nir_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              rstn_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [DATA_W-1:0] s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic      [1:0]        s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic      [DATA_W-1:0] s_axi_rdata_o,
   output logic      [1:0]        s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   input  wire logic              osc_clk_i,
   output logic      [INC_W-1:0]  inc_shadow_o,
   output logic      [INC_W-1:0]  phase_o,
   output logic                   carry_o
);

   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
      hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = hit(addr, OFF_LOW) | hit(addr, OFF_HIGH) | hit(addr, OFF_UPPER)
             | hit(addr, OFF_SHADOW) | hit(addr, OFF_CTRL) | hit(addr, OFF_STATUS)
             | hit(addr, OFF_PHASE);
   endfunction

   // Write channel holding state
   logic              awready_q;
   logic              awready_d;
   logic              wready_q;
   logic              wready_d;
   logic              aw_hold_q;
   logic              aw_hold_d;
   logic              w_hold_q;
   logic              w_hold_d;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [ADDR_W-1:0] aw_addr_d;
   logic [DATA_W-1:0] w_data_q;
   logic [DATA_W-1:0] w_data_d;
   logic [3:0]        w_strb_q;
   logic [3:0]        w_strb_d;
   logic              bvalid_q;
   logic              bvalid_d;
   logic [1:0]        bresp_q;
   logic [1:0]        bresp_d;

   // Read channel state
   logic              arready_q;
   logic              arready_d;
   logic              rvalid_q;
   logic              rvalid_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [1:0]        rresp_q;
   logic [1:0]        rresp_d;

   // Block state
   nir_inc_t          regs_q;
   nir_inc_t          regs_d;
   nir_inc_t          shadow_q;
   nir_inc_t          shadow_d;
   logic              pending_q;
   logic              pending_d;
   logic              run_q;
   logic              run_d;
   logic              osc_prev_q;

   logic              aw_take;
   logic              w_take;
   logic              aw_have;
   logic              w_have;
   logic              do_wr;
   logic              b_done;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_lane0;
   logic              wr_low;
   logic              wr_high;
   logic              wr_upper;
   logic              wr_ctrl;
   logic              ar_take;
   logic              r_done;
   logic [DATA_W-1:0] rd_word;
   logic              osc_fall;
   logic              load_shadow;
   logic              acc_step;

   // Address and data may arrive in either order; each is held until both are in
   assign aw_take  = s_axi_awvalid_i & awready_q;
   assign w_take   = s_axi_wvalid_i & wready_q;
   assign aw_have  = aw_hold_q | aw_take;
   assign w_have   = w_hold_q | w_take;
   assign do_wr    = aw_have & w_have;
   assign b_done   = bvalid_q & s_axi_bready_i;
   assign wr_addr  = aw_take ? s_axi_awaddr_i : aw_addr_q;
   assign wr_data  = w_take ? s_axi_wdata_i : w_data_q;
   assign wr_strb  = w_take ? s_axi_wstrb_i : w_strb_q;

   // Only lane 0 carries register bits; other lanes fall on read-as-zero space
   assign wr_lane0 = do_wr & wr_strb[0];
   assign wr_low   = wr_lane0 & hit(wr_addr, OFF_LOW);
   assign wr_high  = wr_lane0 & hit(wr_addr, OFF_HIGH);
   assign wr_upper = wr_lane0 & hit(wr_addr, OFF_UPPER);
   assign wr_ctrl  = wr_lane0 & hit(wr_addr, OFF_CTRL);

   // Readies drop on take and come back once the response is accepted
   assign awready_d = aw_take ? 1'b0 : (b_done ? 1'b1 : awready_q);
   assign wready_d  = w_take ? 1'b0 : (b_done ? 1'b1 : wready_q);
   assign aw_hold_d = (aw_hold_q | aw_take) & ~do_wr;
   assign w_hold_d  = (w_hold_q | w_take) & ~do_wr;
   assign aw_addr_d = aw_take ? s_axi_awaddr_i : aw_addr_q;
   assign w_data_d  = w_take ? s_axi_wdata_i : w_data_q;
   assign w_strb_d  = w_take ? s_axi_wstrb_i : w_strb_q;
   assign bvalid_d  = do_wr ? 1'b1 : (b_done ? 1'b0 : bvalid_q);
   assign bresp_d   = do_wr ? (mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR) : bresp_q;

   // Register file, built whole so the struct has a single driver
   assign regs_d = '{
      upper: wr_upper ? wr_data[3:0] : regs_q.upper,
      high:  wr_high  ? wr_data[7:0] : regs_q.high,
      low:   wr_low   ? wr_data[7:0] : regs_q.low
   };
   assign run_d        = wr_ctrl ? wr_data[CTRL_RUN_BIT] : run_q;

   // Oscillator input is sampled, so a falling edge is a high-then-low pair
   assign osc_fall    = osc_prev_q & ~osc_clk_i;
   assign load_shadow = pending_q & osc_fall;
   // A low write in the load cycle re-arms, so the newer value is not lost
   assign pending_d   = wr_low | (pending_q & ~osc_fall);
   // Takes the registers as they stand, including any pending write's neighbours
   assign shadow_d    = load_shadow ? regs_q : shadow_q;
   assign acc_step    = osc_fall & run_q;

   // Read path; one cycle of latency
   assign ar_take   = s_axi_arvalid_i & arready_q;
   assign r_done    = rvalid_q & s_axi_rready_i;
   assign rd_word   = hit(s_axi_araddr_i, OFF_LOW)    ? {24'h000000, regs_q.low} :
                      hit(s_axi_araddr_i, OFF_HIGH)   ? {24'h000000, regs_q.high} :
                      hit(s_axi_araddr_i, OFF_UPPER)  ? {28'h0000000, regs_q.upper} :
                      hit(s_axi_araddr_i, OFF_SHADOW) ? {12'h000, shadow_q} :
                      hit(s_axi_araddr_i, OFF_CTRL)   ? {31'h0, run_q} :
                      hit(s_axi_araddr_i, OFF_STATUS) ? {30'h0, osc_prev_q, pending_q} :
                      hit(s_axi_araddr_i, OFF_PHASE)  ? {12'h000, phase_o} :
                      32'h00000000;
   assign arready_d = ar_take ? 1'b0 : (r_done ? 1'b1 : arready_q);
   assign rvalid_d  = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_q);
   assign rdata_d   = ar_take ? rd_word : rdata_q;
   assign rresp_d   = ar_take ? (mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR) : rresp_q;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= awready_d;
         wready_q  <= wready_d;
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= 4'h0;
      end else begin
         aw_addr_q <= aw_addr_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // One reset serves every reset source; all share the same values
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         regs_q     <= INC_RST;
         shadow_q   <= INC_RST;
      end else begin
         regs_q     <= regs_d;
         shadow_q   <= shadow_d;
      end
   end

   // Previous sample resets low; a fall needs a seen high first, so no false edge
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pending_q  <= 1'b0;
         run_q      <= CTRL_RUN_RST;
         osc_prev_q <= 1'b0;
      end else begin
         pending_q  <= pending_d;
         run_q      <= run_d;
         osc_prev_q <= osc_clk_i;
      end
   end

   // Fed from the shadow only, so a half-written value never steps the phase
   nir_phase_acc u_acc (
      .mclk_i  (mclk_i),
      .rstn_i  (rstn_i),
      .step_i  (acc_step),
      .inc_i   (shadow_q),
      .phase_o (phase_o),
      .carry_o (carry_o)
   );

   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o  = wready_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;
   assign inc_shadow_o    = shadow_q;

endmodule

/* nir_properties.sv */
// Port-level checks for the increment register block.
// Assumes it is bound into nir_top; osc_clk_i is sampled on mclk_i.
`timescale 1ns/1ps
module nir_properties
   import nir_pkg::*;
(
   input wire logic              mclk_i,
   input wire logic              rstn_i,
   input wire logic              s_axi_awvalid_i,
   input wire logic              s_axi_awready_o,
   input wire logic              s_axi_wvalid_i,
   input wire logic              s_axi_wready_o,
   input wire logic              s_axi_bvalid_o,
   input wire logic              s_axi_bready_i,
   input wire logic [1:0]        s_axi_bresp_o,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic              s_axi_arvalid_i,
   input wire logic              s_axi_arready_o,
   input wire logic [DATA_W-1:0] s_axi_rdata_o,
   input wire logic              s_axi_rvalid_o,
   input wire logic              osc_clk_i,
   input wire logic [INC_W-1:0]  inc_shadow_o,
   input wire logic [INC_W-1:0]  phase_o,
   input wire logic              carry_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   AST_RESET_VALUES:
      assert property ($rose(rstn_i) |-> inc_shadow_o == INC_RST && phase_o == '0)
      else $error("Buffer or phase not at reset value");
   // A load shows one cycle after the edge that saw the fall
   AST_SHADOW_ON_FALL:
      assert property ($changed(inc_shadow_o) |-> $past(osc_clk_i, 2) && !$past(osc_clk_i))
      else $error("Buffer changed without an oscillator fall");
   AST_PHASE_FROM_SHADOW:
      assert property ($changed(phase_o) |-> phase_o - $past(phase_o) == $past(inc_shadow_o))
      else $error("Phase step differs from buffered increment");
   AST_UPPER_READ_ZERO:
      assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == OFF_UPPER
                       |=> s_axi_rdata_o[31:4] == '0)
      else $error("Upper register unused bits not zero");
   AST_READ_LATENCY:
      assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("Read answer not one cycle after address");
   AST_WRITE_ANSWER:
      assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                       |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
      else $error("Write answer not one cycle after take");
   AST_WRITE_RELEASE:
      assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
      else $error("Write channel not free after response");

   COV_SHADOW_LOAD: cover property ($changed(inc_shadow_o));
   COV_CARRY: cover property (carry_o);
   COV_SLVERR: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule

bind nir_top nir_properties nir_properties_inst (
   .mclk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
   .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_araddr_i, .s_axi_arvalid_i,
   .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .osc_clk_i, .inc_shadow_o, .phase_o,
   .carry_o
);

/* tb.sv */
// Self-checking bench for the increment register block.
// Assumes the bench alone drives the register bus and the oscillator clock.
`timescale 1ns/1ps
module tb
   import nir_pkg::*;
;
   logic mclk_i = 1'b0, rstn_i = 1'b0, osc_clk_i = 1'b1;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
   logic [DATA_W-1:0] s_axi_wdata_i = '0, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i = '0, up_m;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [INC_W-1:0] inc_shadow_o, phase_o, sh_m, ph_m, v;
   logic [7:0] lo_m, hi_m;
   logic carry_o, pend_m, run_m;
   int fails = 0;
   int tests_run = 0;

   always #2 mclk_i = ~mclk_i;

   nir_top nir_top_inst (
      .mclk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
      .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
      .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .osc_clk_i, .inc_shadow_o, .phase_o,
      .carry_o
   );

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic mreset();
      {up_m, hi_m, lo_m} = INC_RST;
      sh_m = INC_RST;
      ph_m = '0;
      pend_m = 1'b0;
      run_m = 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      // Waits as long as it takes; only the watchdog ends a stuck write
      do begin
         @(posedge mclk_i);
         if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      chk(s_axi_bresp_o, er);
      if (s[0] && er == RESP_OKAY) begin
         case (a)
            OFF_LOW: begin
               lo_m = d[7:0];
               pend_m = 1'b1;
            end
            OFF_HIGH: hi_m = d[7:0];
            OFF_UPPER: up_m = d[3:0];
            OFF_CTRL: run_m = d[0];
            default: ;
         endcase
      end
      // Idle edge, so the next call never re-raises in this time step
      @(posedge mclk_i);
   endtask

   // Expected read word of a register other than control and status, from the bench's model
   function automatic logic [DATA_W-1:0] exp_word(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_LOW:    exp_word = {24'h000000, lo_m};
         OFF_HIGH:   exp_word = {24'h000000, hi_m};
         OFF_UPPER:  exp_word = {28'h0000000, up_m};
         OFF_SHADOW: exp_word = {12'h000, sh_m};
         OFF_PHASE:  exp_word = {12'h000, ph_m};
         default:    exp_word = 32'h00000000;
      endcase
   endfunction

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input logic [1:0] er);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      chk(s_axi_rdata_o, exp);
      chk(s_axi_rresp_o, er);
      @(posedge mclk_i);
   endtask

   // One oscillator period; the accumulator adds the old buffer value
   task automatic fall();
      logic [INC_W:0] sum_m;
      sum_m = {1'b0, ph_m} + {1'b0, sh_m};
      osc_clk_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      // Carry stands only in the cycle after the stepping edge
      chk(carry_o, run_m & sum_m[INC_W]);
      osc_clk_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      if (run_m) ph_m = sum_m[INC_W-1:0];
      if (pend_m) sh_m = {up_m, hi_m, lo_m};
      pend_m = 1'b0;
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk_i);
      fails++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'h8760));
      mreset();
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(posedge mclk_i);
      chk(inc_shadow_o, INC_RST);
      rdchk(OFF_LOW, 32'h00000001, RESP_OKAY);
      rdchk(OFF_HIGH, 32'h00000000, RESP_OKAY);
      rdchk(OFF_UPPER, 32'h00000000, RESP_OKAY);
      rdchk(OFF_STATUS, 32'h00000002, RESP_OKAY);
      wr(OFF_UPPER, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rdchk(OFF_UPPER, 32'h0000000F, RESP_OKAY);
      // Accumulator still stopped, so this fall leaves the phase at zero
      fall();
      chk(phase_o, ph_m);
      wr(OFF_CTRL, 32'h00000001, 4'hF, RESP_OKAY);
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 20'hFFFFF : (i == 1) ? 20'h00000 : 20'($urandom);
         wr(OFF_UPPER, {28'($urandom), v[19:16]}, 4'hF, RESP_OKAY);
         wr(OFF_HIGH, {24'($urandom), v[15:8]}, 4'hF, RESP_OKAY);
         wr(OFF_LOW, {24'($urandom), v[7:0]}, 4'hF, RESP_OKAY);
         rdchk(OFF_UPPER, exp_word(OFF_UPPER), RESP_OKAY);
         rdchk(OFF_STATUS, 32'h00000003, RESP_OKAY);
         chk(inc_shadow_o, sh_m);
         fall();
         chk(inc_shadow_o, sh_m);
         chk(phase_o, ph_m);
      end
      rdchk(OFF_PHASE, exp_word(OFF_PHASE), RESP_OKAY);
      // Low write without its lane, then a high write: neither may load
      wr(OFF_LOW, 32'h00000055, 4'hE, RESP_OKAY);
      rdchk(OFF_STATUS, 32'h00000002, RESP_OKAY);
      rdchk(OFF_LOW, exp_word(OFF_LOW), RESP_OKAY);
      wr(OFF_HIGH, 32'h000000A5, 4'hF, RESP_OKAY);
      fall();
      chk(inc_shadow_o, sh_m);
      rdchk(OFF_SHADOW, exp_word(OFF_SHADOW), RESP_OKAY);
      rdchk(12'h100, '0, RESP_SLVERR);
      wr(12'h100, 32'h00000001, 4'hF, RESP_SLVERR);
      rstn_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      mreset();
      @(posedge mclk_i);
      chk(inc_shadow_o, INC_RST);
      chk(phase_o, '0);
      rdchk(OFF_LOW, 32'h00000001, RESP_OKAY);
      wrap_up();
   end
endmodule
